// File: shared/flash_core_defs.vh
`ifndef FLASH_CORE_DEFS_VH
`define FLASH_CORE_DEFS_VH

// ----------------------------------------
// array shape
// ----------------------------------------
`define FC_ROWS          1024
`define FC_ROW_BYTES     64
`define FC_SECT_ROWS     8
`define FC_WORDS         32768
`define FC_WIDX_LAST     15'h7FFF
`define FC_WIDX_ZERO     15'h0000
`define FC_SECT_LO       8'h00
`define FC_SECT_HI       8'hFF
`define FC_ERASED_WORD   16'hFFFF
`define FC_ERASED_BYTE   8'hFF

// ----------------------------------------
// command codes (arbitrary encodings)
// ----------------------------------------
`define FC_CMD_PROGRAM   8'h01
`define FC_CMD_SECT_ERS  8'h02
`define FC_CMD_MASS_ERS  8'h03
`define FC_CMD_VERIFY    8'h04

// ----------------------------------------
// timing
// ----------------------------------------
`define FC_PROG_TICKS    8'h0A
`define FC_DIV_RESET     7'h00

`endif

// File: hw/flash_tick_gen.v
`timescale 1ns/100ps
`default_nettype none
`include "flash_core_defs.vh"

// ----------------------------------------
// tick divider for the operation timing
// ----------------------------------------
module flash_tick_gen (
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire [6:0] div,
  output reg        tick_r
);
  reg [6:0] cnt_r;

  // tick every div+1 cycles while an operation runs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= `FC_DIV_RESET;
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r  <= `FC_DIV_RESET;
      tick_r <= 1'b0;
    end else if (cnt_r == div) begin
      cnt_r  <= `FC_DIV_RESET;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 7'h01;
      tick_r <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// File: hw/flash_core.v
`timescale 1ns/100ps
`default_nettype none
`include "flash_core_defs.vh"

module flash_core (
  input  wire        clk,
  input  wire        rst,
  input  wire        rd_req,
  input  wire [15:0] rd_addr,
  input  wire        rd_word,
  output reg  [15:0] rd_data_r,
  output reg         rd_valid_r,
  output reg         rd_refused_r,
  input  wire        div_wr,
  input  wire [6:0]  div_val,
  output reg         divider_loaded_flag_r,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_addr,
  input  wire [15:0] cmd_data,
  output reg         cmd_ready_r,
  output reg         cmd_done_r,
  output reg         verify_blank_r,
  input  wire        complete_int_en,
  input  wire        empty_int_en,
  output reg         complete_int_r,
  output reg         empty_int_r
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_PROG  = 4'b0010;
  localparam [3:0] S_ERASE = 4'b0100;
  localparam [3:0] S_VERIF = 4'b1000;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function [9:0] row_of;
    input [15:0] a;
    row_of = a[15:6];
  endfunction

  function [14:0] widx;
    input [15:0] a;
    widx = {row_of(a), a[5:1]};
  endfunction

  // program only clears bits; zero means programmed
  reg [15:0] mem [0:`FC_WORDS-1];

  reg [3:0]  state_r;
  reg [6:0]  div_r;
  reg        buf_full_r;
  reg [7:0]  buf_code_r;
  reg [15:0] buf_addr_r;
  reg [15:0] buf_data_r;
  reg [15:0] act_addr_r;
  reg [15:0] act_data_r;
  reg [14:0] ptr_r;
  reg [14:0] end_r;
  reg [7:0]  cnt_r;
  reg        rd_second_r;
  reg [14:0] rd_next_r;
  reg        mem_we;
  reg [14:0] mem_widx;
  reg [15:0] mem_wdata;
  wire       tick;
  wire       run;
  wire       busy;
  wire       done_nxt;
  wire       empty_nxt;
  wire       take_cmd;

  assign run  = ~state_r[0];
  assign busy = run | buf_full_r;
  assign take_cmd = cmd_valid & cmd_ready_r;

  flash_tick_gen u_tick (
    .clk    (clk),
    .rst    (rst),
    .run    (run),
    .div    (div_r),
    .tick_r (tick)
  );

  // ----------------------------------------
  // divider, write once
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r                 <= `FC_DIV_RESET;
      divider_loaded_flag_r <= 1'b0;
    end else if (div_wr && !divider_loaded_flag_r) begin
      div_r                 <= div_val;
      divider_loaded_flag_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // array write port, driven by sequencer only
  // ----------------------------------------
  always @* begin
    mem_we    = 1'b0;
    mem_widx  = ptr_r;
    mem_wdata = `FC_ERASED_WORD;
    if (state_r == S_PROG && tick && cnt_r == `FC_PROG_TICKS - 8'h01) begin
      mem_we    = 1'b1;
      mem_widx  = widx(act_addr_r);
      // and-in keeps already programmed zeros; re-programming is the host's fault
      mem_wdata = mem[widx(act_addr_r)] & act_data_r;
    end else if (state_r == S_ERASE && tick) begin
      mem_we = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (mem_we)
      mem[mem_widx] <= mem_wdata;
  end

  // ----------------------------------------
  // command buffer and sequencer
  // ----------------------------------------
  assign done_nxt  = (state_r == S_IDLE) && !buf_full_r && !take_cmd;
  assign empty_nxt = !buf_full_r && !take_cmd;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r        <= S_IDLE;
      buf_full_r     <= 1'b0;
      buf_code_r     <= 8'h00;
      buf_addr_r     <= 16'h0000;
      buf_data_r     <= 16'h0000;
      act_addr_r     <= 16'h0000;
      act_data_r     <= 16'h0000;
      ptr_r          <= `FC_WIDX_ZERO;
      end_r          <= `FC_WIDX_ZERO;
      cnt_r          <= 8'h00;
      verify_blank_r <= 1'b0;
      cmd_ready_r    <= 1'b0;
      cmd_done_r     <= 1'b0;
      complete_int_r <= 1'b0;
      empty_int_r    <= 1'b0;
    end else begin
      // second pipeline stage: one command may wait behind the active one
      if (take_cmd) begin
        buf_full_r <= 1'b1;
        buf_code_r <= cmd_code;
        buf_addr_r <= cmd_addr;
        buf_data_r <= cmd_data;
      end
      case (state_r)
        S_IDLE: begin
          if (buf_full_r) begin
            buf_full_r <= take_cmd;
            act_addr_r <= buf_addr_r;
            act_data_r <= buf_data_r;
            cnt_r      <= 8'h00;
            case (buf_code_r)
              `FC_CMD_PROGRAM: begin
                state_r <= S_PROG;
              end
              `FC_CMD_SECT_ERS: begin
                ptr_r   <= {buf_addr_r[15:9], `FC_SECT_LO};
                end_r   <= {buf_addr_r[15:9], `FC_SECT_HI};
                state_r <= S_ERASE;
              end
              `FC_CMD_MASS_ERS: begin
                ptr_r   <= `FC_WIDX_ZERO;
                end_r   <= `FC_WIDX_LAST;
                state_r <= S_ERASE;
              end
              `FC_CMD_VERIFY: begin
                ptr_r          <= `FC_WIDX_ZERO;
                end_r          <= `FC_WIDX_LAST;
                verify_blank_r <= 1'b1;
                state_r        <= S_VERIF;
              end
              default: begin
                state_r <= S_IDLE;
              end
            endcase
          end
        end
        S_PROG: begin
          if (tick) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == `FC_PROG_TICKS - 8'h01)
              state_r <= S_IDLE;
          end
        end
        S_ERASE: begin
          if (tick) begin
            ptr_r <= ptr_r + 15'h0001;
            if (ptr_r == end_r)
              state_r <= S_IDLE;
          end
        end
        S_VERIF: begin
          if (tick) begin
            if (mem[ptr_r] != `FC_ERASED_WORD)
              verify_blank_r <= 1'b0;
            ptr_r <= ptr_r + 15'h0001;
            if (ptr_r == end_r)
              state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
      // commands wait for the divider, else timing is undefined
      cmd_ready_r    <= empty_nxt && divider_loaded_flag_r;
      cmd_done_r     <= done_nxt;
      complete_int_r <= done_nxt && complete_int_en;
      empty_int_r    <= empty_nxt && empty_int_en;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_r    <= 16'h0000;
      rd_valid_r   <= 1'b0;
      rd_refused_r <= 1'b0;
      rd_second_r  <= 1'b0;
      rd_next_r    <= `FC_WIDX_ZERO;
    end else begin
      rd_valid_r   <= 1'b0;
      rd_refused_r <= 1'b0;
      if (rd_second_r) begin
        rd_data_r[7:0] <= mem[rd_next_r][15:8];
        rd_valid_r     <= 1'b1;
        rd_second_r    <= 1'b0;
      end else if (rd_req) begin
        if (busy) begin
          rd_refused_r <= 1'b1;
        end else if (rd_word && rd_addr[0]) begin
          rd_data_r[15:8] <= mem[widx(rd_addr)][7:0];
          rd_next_r       <= widx(rd_addr) + 15'h0001;
          rd_second_r     <= 1'b1;
        end else if (rd_word) begin
          rd_data_r  <= mem[widx(rd_addr)];
          rd_valid_r <= 1'b1;
        end else begin
          rd_data_r  <= {8'h00, rd_addr[0] ? mem[widx(rd_addr)][7:0]
                                           : mem[widx(rd_addr)][15:8]};
          rd_valid_r <= 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// File: verification/flash_core_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// checks at the core's ports
// ----
module flash_core_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        rd_req,
  input wire logic [15:0] rd_addr,
  input wire logic        rd_word,
  input wire logic        rd_valid_r,
  input wire logic        rd_refused_r,
  input wire logic        div_wr,
  input wire logic        divider_loaded_flag_r,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready_r,
  input wire logic        cmd_done_r,
  input wire logic        complete_int_en,
  input wire logic        empty_int_en,
  input wire logic        complete_int_r,
  input wire logic        empty_int_r
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // quiet cycle first, so no split read is pending
  sequence s_one;
    !rd_req ##1 rd_req && !(rd_word && rd_addr[0]) && cmd_done_r;
  endsequence
  sequence s_mis;
    !rd_req ##1 rd_req && rd_word && rd_addr[0] && cmd_done_r;
  endsequence
  AST_RD_ONE: assert property (s_one |=> rd_valid_r) else $error("read late");
  AST_RD_MIS: assert property (s_mis |=> !rd_valid_r ##1 rd_valid_r)
    else $error("split read");
  AST_REFUSE: assert property (rd_refused_r |-> !$past(cmd_done_r))
    else $error("refused idle");
  AST_RDY_DIV: assert property (cmd_ready_r |-> divider_loaded_flag_r)
    else $error("ready early");
  AST_DIV_SET: assert property (div_wr |=> divider_loaded_flag_r) else $error("no flag");
  AST_DIV_WHY: assert property ($rose(divider_loaded_flag_r) |-> $past(div_wr))
    else $error("stray flag");
  AST_TAKE: assert property (cmd_valid && cmd_ready_r |=> !cmd_ready_r && !cmd_done_r)
    else $error("take");
  // a take in the same cycle ends the idle span, so no completion follows
  AST_INT_ON: assert property (cmd_done_r && complete_int_en && !(cmd_valid && cmd_ready_r)
    |=> complete_int_r)
    else $error("int");
  AST_INT_OFF: assert property (!complete_int_en |=> !complete_int_r) else $error("int");
  AST_EMP_OFF: assert property (!empty_int_en |=> !empty_int_r) else $error("empty");
endmodule
bind flash_core flash_core_chk u_chk (.clk, .rst, .rd_req, .rd_addr, .rd_word, .rd_valid_r,
  .rd_refused_r, .div_wr, .divider_loaded_flag_r, .cmd_valid, .cmd_ready_r, .cmd_done_r,
  .complete_int_en, .empty_int_en, .complete_int_r, .empty_int_r);
`default_nettype wire

// File: verification/flash_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// host side: one command strobe, held until taken
// ----
module flash_host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic cmd_ready_r,
  output var  logic cmd_valid
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_valid <= 1'b0;
    end else if (cmd_valid && cmd_ready_r) begin
      cmd_valid <= 1'b0;
    end else if (go) begin
      // address, data and code go as one step
      cmd_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: verification/flash_array_access_and_command_core_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_core_defs.vh"
// ----
// mass erase with lockout, blank check, programs, read table, then lockout, erase and interrupt cases
// ----
module flash_array_access_and_command_core_test;
  logic        clk = 1'b0, rst = 1'b1, rd_req = 1'b0, rd_word = 1'b0, div_wr = 1'b0;
  logic        go = 1'b0, complete_int_en = 1'b1, empty_int_en = 1'b1;
  logic [15:0] rd_addr = 16'h0000, cmd_addr = 16'h0000, cmd_data = 16'h0000;
  logic [7:0]  cmd_code = 8'h00;
  logic [6:0]  div_val = 7'h00;
  wire  [15:0] rd_data_r;
  wire         rd_valid_r, rd_refused_r, divider_loaded_flag_r, cmd_valid, cmd_ready_r;
  wire         cmd_done_r, verify_blank_r, complete_int_r, empty_int_r;
  int          miscompares = 0, tests_run = 0, i, n;
  logic [31:0] prog [0:3] = '{32'h0000_1234, 32'h0002_5678, 32'h01FE_0F0F, 32'h0200_A5A5};
  logic [32:0] rows [0:7] = '{{16'h0000, 1'b1, 16'h1234}, {16'h0001, 1'b0, 16'h0034},
    {16'h0000, 1'b0, 16'h0012}, {16'h0001, 1'b1, 16'h3456}, {16'h0004, 1'b1, 16'hFFFF},
    {16'h0200, 1'b1, 16'hA5A5}, {16'h01FF, 1'b1, 16'h0FA5}, {16'h0003, 1'b0, 16'h0078}};
  flash_core DUT (.clk, .rst, .rd_req, .rd_addr, .rd_word, .rd_data_r, .rd_valid_r,
    .rd_refused_r, .div_wr, .div_val, .divider_loaded_flag_r, .cmd_valid, .cmd_code,
    .cmd_addr, .cmd_data, .cmd_ready_r, .cmd_done_r, .verify_blank_r, .complete_int_en,
    .empty_int_en, .complete_int_r, .empty_int_r);
  flash_host_model host (.clk, .rst, .go, .cmd_ready_r, .cmd_valid);
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic w);
    @(posedge clk);
    rd_req  <= 1'b1;
    rd_addr <= a;
    rd_word <= w;
    @(posedge clk);
    rd_req <= 1'b0;
    if (w && a[0]) @(posedge clk);
    @(negedge clk);
  endtask
  // fields stay put until the next command, well past the take
  task automatic issue(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    go       <= 1'b1;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    for (n = 0; n < 20 && cmd_valid === 1'b1; n++) @(negedge clk);
  endtask
  task automatic idle;
    for (n = 0; n < 40000 && cmd_done_r !== 1'b1; n++) @(negedge clk);
    chk("done", {17'h0_0000, cmd_done_r}, 18'h0_0001);
  endtask
  task conclude;
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  // whole run is about 66000 cycles
  initial begin
    #(90000 * 50);
    miscompares++;
    conclude;
  end
  initial begin
    repeat (5) @(posedge clk);
    chk("rst", {15'h0000, divider_loaded_flag_r, cmd_ready_r, cmd_done_r}, 18'h0_0000);
    rst <= 1'b0;
    @(posedge clk);
    div_wr <= 1'b1;
    @(negedge clk);
    chk("pre", {15'h0000, divider_loaded_flag_r, cmd_ready_r, cmd_done_r}, 18'h0_0001);
    @(posedge clk);
    div_wr <= 1'b0;
    @(negedge clk);
    chk("flag", {15'h0000, divider_loaded_flag_r, cmd_ready_r, cmd_done_r}, 18'h0_0005);
    issue(`FC_CMD_MASS_ERS, 16'h0000, 16'h0000);
    rd(16'h8000, 1'b1);
    chk("lock", {rd_refused_r, rd_valid_r, 16'h0000}, 18'h2_0000);
    idle;
    issue(`FC_CMD_VERIFY, 16'h0000, 16'h0000);
    idle;
    chk("blank", {17'h0_0000, verify_blank_r}, 18'h0_0001);
    for (i = 0; i < 4; i++) begin
      issue(`FC_CMD_PROGRAM, prog[i][31:16], prog[i][15:0]);
      idle;
    end
    for (i = 0; i < 8; i++) begin
      rd(rows[i][32:17], rows[i][16]);
      chk("read", {rd_refused_r, rd_valid_r, rd_data_r}, {2'b01, rows[i][15:0]});
    end
    issue(`FC_CMD_SECT_ERS, 16'h0000, 16'h0000);
    rd(16'h0200, 1'b0);
    chk("lock", {rd_refused_r, rd_valid_r, 16'h0000}, 18'h2_0000);
    idle;
    rd(16'h01FE, 1'b1);
    chk("sect", {rd_refused_r, rd_valid_r, rd_data_r}, 18'h1_FFFF);
    rd(16'h0200, 1'b1);
    chk("next", {rd_refused_r, rd_valid_r, rd_data_r}, 18'h1_A5A5);
    chk("ints", {16'h0000, complete_int_r, empty_int_r}, 18'h0_0003);
    @(posedge clk);
    complete_int_en <= 1'b0;
    empty_int_en    <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("ints", {16'h0000, complete_int_r, empty_int_r}, 18'h0_0000);
    // mid-run reset: flag must drop and stay clear until a new divider write
    rst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("rerun", {15'h0000, divider_loaded_flag_r, cmd_ready_r, cmd_done_r}, 18'h0_0001);
    conclude;
  end
endmodule
`default_nettype wire
